// ### rtl/adc_conversion_sequencer.sv
`timescale 1ns/1ps
module adc_conversion_sequencer (
    input  wire logic                                core_clk,
    input  wire logic                                reset_n,
    input  wire logic [adc_seq_pkg::ADDR_W-1:0]      regAddr,
    input  wire logic [adc_seq_pkg::DATA_W-1:0]      regWrData,
    input  wire logic                                regWrite,
    input  wire logic                                regRead,
    output logic      [adc_seq_pkg::DATA_W-1:0]      regRdData,
    input  wire logic                                stopMode,
    input  wire logic                                altClkTick,
    input  wire logic                                asyncClkPin,
    input  wire logic                                compGreater,
    output logic                                     converterOn,
    output logic                                     asyncOscOn,
    output logic                                     sampleOn,
    output logic      [adc_seq_pkg::APPROX_W-1:0]    dacCode,
    output logic      [adc_seq_pkg::CHAN_W-1:0]      channelSel,
    output logic                                     completionIrq
);
    localparam int StartMax = adc_seq_pkg::ASYNC_START_CYC;

    typedef struct packed {
        adc_seq_pkg::conv_state_e                state;
        logic [adc_seq_pkg::CNT_W-1:0]           cnt;
        logic [adc_seq_pkg::APPROX_W-1:0]        sar;
        logic [adc_seq_pkg::APPROX_W-1:0]        trial;
        logic [adc_seq_pkg::IDX_W-1:0]           bitIdx;
        logic                                    irqEn;
        logic                                    cont;
        logic [adc_seq_pkg::CHAN_W-1:0]          chan;
        logic [adc_seq_pkg::DATA_W-1:0]          clkCfg;
        logic [adc_seq_pkg::RES_W-1:0]           result;
        logic                                    flag;
        logic                                    readLock;
        logic                                    stopPrev;
        logic [2:0]                              asyncSync;
        logic [adc_seq_pkg::DATA_W-1:0]          rdData;
        logic                                    converterOn;
        logic                                    asyncOscOn;
        logic                                    sampleOn;
        logic                                    irqReq;
        logic [7:0]                              chkTicks;
    } seq_s;

    seq_s                                st_r;
    seq_s                                st_nxt;
    logic                                asyncEn;
    logic                                mode10;
    logic                                longSmp;
    logic                                srcTick;
    logic                                convTick;
    logic                                divClear;
    logic                                scWr;
    logic                                ccWr;
    logic                                stopAbort;
    logic                                abort;
    logic [adc_seq_pkg::CNT_W-1:0]       sampleTicks;
    logic [adc_seq_pkg::IDX_W-1:0]       lastIdx;
    logic [7:0]                          convMax;
    logic [adc_seq_pkg::APPROX_W-1:0]    sarNew;
    logic [adc_seq_pkg::APPROX_W-1:0]    nextBit;

    function automatic logic [adc_seq_pkg::RES_W-1:0] roundCode(
        input logic [adc_seq_pkg::APPROX_W-1:0] a,
        input logic                             wide
    );
        logic [adc_seq_pkg::RES_W:0] s;
        logic [adc_seq_pkg::RES_W:0] lim;
        // one guard bit below the code gives round-to-nearest
        if (wide) begin
            s = {1'b0, a[adc_seq_pkg::APPROX_W-1:1]} + (adc_seq_pkg::RES_W+1)'(a[0]);
            lim = {1'b0, adc_seq_pkg::RES10_MAX};
        end else begin
            s = (adc_seq_pkg::RES_W+1)'(a[adc_seq_pkg::APPROX_W-1:3]) +
                (adc_seq_pkg::RES_W+1)'(a[2]);
            lim = {1'b0, adc_seq_pkg::RES8_MAX};
        end
        // saturation is what widens the top code to one and a half steps
        if (s > lim) begin
            s = lim;
        end
        return s[adc_seq_pkg::RES_W-1:0];
    endfunction

    assign asyncEn = st_r.clkCfg[adc_seq_pkg::CC_ASYNC_BIT];
    assign mode10  = st_r.clkCfg[adc_seq_pkg::CC_MODE10_BIT];
    assign longSmp = st_r.clkCfg[adc_seq_pkg::CC_LONG_BIT];
    assign scWr = regWrite && regAddr == adc_seq_pkg::OFS_STATUS_CTRL;
    assign ccWr = regWrite && regAddr == adc_seq_pkg::OFS_CLOCK_CFG;
    assign stopAbort = stopMode && !st_r.stopPrev && !asyncEn;
    assign abort = scWr || ccWr || stopAbort;
    assign sampleTicks = longSmp ? adc_seq_pkg::SAMPLE_LONG_TICKS
                                 : adc_seq_pkg::SAMPLE_SHORT_TICKS;
    assign lastIdx = mode10 ? adc_seq_pkg::LAST_IDX_10 : adc_seq_pkg::LAST_IDX_8;
    assign convMax = mode10 ? (longSmp ? adc_seq_pkg::CONV_MAX_10L : adc_seq_pkg::CONV_MAX_10S)
                            : (longSmp ? adc_seq_pkg::CONV_MAX_8L : adc_seq_pkg::CONV_MAX_8S);

    // async source edges come from the second and third stage only
    always_comb begin
        if (asyncEn) begin
            srcTick = st_r.asyncSync[1] && !st_r.asyncSync[2];
        end else if (st_r.clkCfg[adc_seq_pkg::CC_SEL_BIT]) begin
            srcTick = 1'b1;
        end else begin
            srcTick = altClkTick;
        end
    end

    // the divider restarts at each sample phase so every window is whole
    assign divClear = !(st_r.state inside {adc_seq_pkg::ST_SAMPLE, adc_seq_pkg::ST_CONVERT});

    converter_clock_divider #(
        .DIV_W (adc_seq_pkg::DIV_W)
    ) uDivider (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clear    (divClear),
        .srcTick  (srcTick),
        .divSel   (st_r.clkCfg[adc_seq_pkg::CC_DIV_LSB +: adc_seq_pkg::DIV_W]),
        .tick     (convTick)
    );

    assign sarNew  = compGreater ? st_r.trial : st_r.sar;
    assign nextBit = {{(adc_seq_pkg::APPROX_W-1){1'b0}}, 1'b1} << (st_r.bitIdx - 1'b1);

    always_comb begin
        st_nxt = st_r;
        st_nxt.asyncSync = {st_r.asyncSync[1:0], asyncClkPin};
        st_nxt.stopPrev = stopMode;
        st_nxt.rdData = '0;
        if (regRead) begin
            unique case (regAddr)
                adc_seq_pkg::OFS_STATUS_CTRL: st_nxt.rdData = {st_r.flag, st_r.irqEn,
                                                               st_r.cont, st_r.chan};
                adc_seq_pkg::OFS_RESULT_HIGH: st_nxt.rdData = mode10 ?
                    adc_seq_pkg::DATA_W'(st_r.result >> adc_seq_pkg::RES8_W) : '0;
                adc_seq_pkg::OFS_RESULT_LOW:  st_nxt.rdData = st_r.result[7:0];
                adc_seq_pkg::OFS_CLOCK_CFG:   st_nxt.rdData = st_r.clkCfg;
                default:                      st_nxt.rdData = '0;
            endcase
            if (regAddr == adc_seq_pkg::OFS_RESULT_HIGH && mode10) begin
                st_nxt.readLock = 1'b1;
            end
            if (regAddr == adc_seq_pkg::OFS_RESULT_LOW) begin
                st_nxt.readLock = 1'b0;
                st_nxt.flag = 1'b0;
            end
        end
        if (scWr) begin
            st_nxt.irqEn = regWrData[adc_seq_pkg::SC_IRQ_BIT];
            st_nxt.cont  = regWrData[adc_seq_pkg::SC_CONT_BIT];
            st_nxt.chan  = regWrData[adc_seq_pkg::CHAN_W-1:0];
            st_nxt.flag  = 1'b0;
        end
        if (ccWr) begin
            st_nxt.clkCfg = regWrData;
        end
        if (abort) begin
            // result untouched, flag kept except on a status write: a finishing round step is dropped
            st_nxt.state = adc_seq_pkg::ST_IDLE;
            st_nxt.cnt = '0;
            st_nxt.trial = '0;
            if (scWr && regWrData[adc_seq_pkg::CHAN_W-1:0] != adc_seq_pkg::CHAN_ALL_ONES) begin
                st_nxt.state = adc_seq_pkg::ST_SYNC;
            end
        end else begin
            unique case (st_r.state)
                adc_seq_pkg::ST_IDLE: begin
                end
                adc_seq_pkg::ST_SYNC: begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                    if (st_r.cnt == adc_seq_pkg::SYNC_LAST) begin
                        st_nxt.cnt = '0;
                        st_nxt.state = asyncEn ? adc_seq_pkg::ST_STARTUP
                                               : adc_seq_pkg::ST_SAMPLE;
                    end
                end
                adc_seq_pkg::ST_STARTUP: begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                    if (st_r.cnt == adc_seq_pkg::ASYNC_START_LAST) begin
                        st_nxt.cnt = '0;
                        st_nxt.state = adc_seq_pkg::ST_SAMPLE;
                    end
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    if (convTick) begin
                        st_nxt.cnt = st_r.cnt + 1'b1;
                        if (st_r.cnt == sampleTicks - 1'b1) begin
                            st_nxt.cnt = '0;
                            st_nxt.state = adc_seq_pkg::ST_CONVERT;
                            st_nxt.sar = '0;
                            st_nxt.bitIdx = adc_seq_pkg::TOP_IDX;
                            st_nxt.trial = {1'b1, {(adc_seq_pkg::APPROX_W-1){1'b0}}};
                        end
                    end
                end
                adc_seq_pkg::ST_CONVERT: begin
                    if (convTick) begin
                        st_nxt.sar = sarNew;
                        if (st_r.bitIdx == lastIdx) begin
                            st_nxt.state = adc_seq_pkg::ST_ROUND;
                        end else begin
                            st_nxt.bitIdx = st_r.bitIdx - 1'b1;
                            st_nxt.trial = sarNew | nextBit;
                        end
                    end
                end
                adc_seq_pkg::ST_ROUND: begin
                    st_nxt.state = adc_seq_pkg::ST_SAMPLE;
                    if (!(mode10 && st_r.readLock)) begin
                        st_nxt.result = roundCode(st_r.sar, mode10);
                        st_nxt.flag = 1'b1;
                        if (!st_r.cont) begin
                            st_nxt.state = adc_seq_pkg::ST_IDLE;
                        end
                    end
                end
                default: st_nxt.state = adc_seq_pkg::ST_IDLE;
            endcase
        end
        st_nxt.converterOn = st_nxt.state != adc_seq_pkg::ST_IDLE;
        st_nxt.asyncOscOn = st_nxt.converterOn && st_nxt.clkCfg[adc_seq_pkg::CC_ASYNC_BIT];
        st_nxt.sampleOn = st_nxt.state == adc_seq_pkg::ST_SAMPLE;
        st_nxt.irqReq = st_nxt.flag && st_nxt.irqEn;
        if (st_r.state inside {adc_seq_pkg::ST_SAMPLE, adc_seq_pkg::ST_CONVERT}) begin
            st_nxt.chkTicks = st_r.chkTicks + 8'(convTick);
        end else begin
            st_nxt.chkTicks = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData     = st_r.rdData;
    assign converterOn   = st_r.converterOn;
    assign asyncOscOn    = st_r.asyncOscOn;
    assign sampleOn      = st_r.sampleOn;
    assign dacCode       = st_r.trial;
    assign channelSel    = st_r.chan;
    assign completionIrq = st_r.irqReq;

    sequence s_restart;
        st_r.state == adc_seq_pkg::ST_SYNC && st_r.cnt == '0;
    endsequence

    sequence s_parked;
        st_r.state == adc_seq_pkg::ST_IDLE && !st_r.converterOn;
    endsequence

    chk_sc_restart:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            scWr && regWrData[adc_seq_pkg::CHAN_W-1:0] != adc_seq_pkg::CHAN_ALL_ONES
            |=> s_restart ##1 st_r.converterOn)
        else $error("status write did not restart conversion");
    chk_sc_park:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            scWr && regWrData[adc_seq_pkg::CHAN_W-1:0] == adc_seq_pkg::CHAN_ALL_ONES
            |=> s_parked)
        else $error("status write with all-ones channel left converter running");
    chk_cfg_abort:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            ccWr |=> s_parked)
        else $error("clock config write did not abort");
    chk_reset_result:
        assert property (@(posedge core_clk)
            !reset_n |=> st_r.result == '0 && !st_r.flag && !completionIrq)
        else $error("result not cleared by reset");
    chk_stop_abort:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            stopAbort && !regWrite |=> st_r.state == adc_seq_pkg::ST_IDLE)
        else $error("stop entry did not abort");
    chk_abort_keeps:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            abort |=> $stable(st_r.result))
        else $error("abort changed result");
    chk_abort_power:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            abort && !scWr |=> !converterOn && !asyncOscOn && !sampleOn)
        else $error("converter not powered down on abort");
    chk_conv_time:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            st_r.state == adc_seq_pkg::ST_ROUND |-> st_r.chkTicks <= convMax)
        else $error("conversion exceeded its clock budget");
    chk_async_start:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            $rose(st_r.state == adc_seq_pkg::ST_STARTUP)
            |-> ##[1:StartMax] st_r.state != adc_seq_pkg::ST_STARTUP)
        else $error("async start-up wait too long");
    chk_sample_len:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            st_r.state == adc_seq_pkg::ST_CONVERT
            && $past(st_r.state) == adc_seq_pkg::ST_SAMPLE |-> st_r.chkTicks == 8'(sampleTicks))
        else $error("sample window length wrong");
    chk_round_range:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            $rose(st_r.flag) && !mode10 |-> st_r.result <= adc_seq_pkg::RES8_MAX)
        else $error("8-bit result out of range");
    chk_done_flag:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            st_r.state == adc_seq_pkg::ST_ROUND && !abort && !(mode10 && st_r.readLock)
            |=> st_r.flag && completionIrq == st_r.irqEn)
        else $error("completion not flagged");
    chk_cont_restart:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            st_r.state == adc_seq_pkg::ST_ROUND && st_r.cont && !abort
            |=> st_r.state == adc_seq_pkg::ST_SAMPLE)
        else $error("continuous mode did not restart");
    chk_blocked:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            st_r.state == adc_seq_pkg::ST_ROUND && mode10 && st_r.readLock && !abort
            |=> $stable(st_r.result) && st_r.state == adc_seq_pkg::ST_SAMPLE)
        else $error("blocked transfer overwrote result");
    chk_abort_noflag:
        assert property (@(posedge core_clk) disable iff (!reset_n)
            abort |=> !$rose(st_r.flag) && !$rose(completionIrq))
        else $error("aborted conversion flagged completion");
endmodule

// ### rtl/adc_seq_pkg.sv
// Overview of operation
// - any status_control_reg write aborts; restarts unless channel field is all ones
// - any converter_clock_config_reg write aborts the conversion at once
// - reset returns both result registers to their reset value
// - stop entry with async_clock_enable clear aborts the conversion
// - non-reset aborts leave the last completed result untouched
// - reset or a non-restarting abort drops the converter to its powered-down idle state
// - 8-bit short sample: first within 18 clocks plus 3 bus, later 16
// - 8-bit long sample: first within 38 clocks plus 3 bus, later 36
// - 10-bit short sample: first within 21 clocks plus 3 bus, later 19
// - 10-bit long sample: first within 41 clocks plus 3 bus, later 39
// - async clock adds at most 5 us start-up to a first conversion
// - sample window 3.5 converter clocks, 23.5 with long_sample_select; the code counts 4 and 24
// - approximation is rounded to nearest 8- or 10-bit code
// - 10-bit mode maps reference range onto 1024 equal steps; the rounding gives code 0 half a step and the top code one and a half
// - clock source from input_clock_select and async enable, ratio from divide field
// - completion stores result, sets complete flag, raises request if enabled
// - continuous mode restarts after every result transfer until aborted
// - 10-bit result blocked while high byte read and low not; restart
// - divide field divides the selected source by 1, 2, 4 or 8
package adc_seq_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] OFS_STATUS_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_RESULT_LOW  = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_CFG   = 3'h3;

    localparam int SC_FLAG_BIT = 7;
    localparam int SC_IRQ_BIT  = 6;
    localparam int SC_CONT_BIT = 5;
    localparam int CHAN_W      = 5;
    localparam logic [CHAN_W-1:0] CHAN_ALL_ONES = 5'h1F;

    localparam int CC_ASYNC_BIT  = 7;
    localparam int CC_DIV_LSB    = 5;
    localparam int DIV_W         = 2;
    localparam int CC_LONG_BIT   = 4;
    localparam int CC_MODE10_BIT = 3;
    localparam int CC_SEL_BIT    = 0;

    localparam int RES_W    = 10;
    localparam int RES8_W   = 8;
    localparam int APPROX_W = RES_W + 1;
    localparam int IDX_W    = 4;
    localparam logic [IDX_W-1:0] TOP_IDX     = 4'hA;
    localparam logic [IDX_W-1:0] LAST_IDX_10 = 4'h0;
    localparam logic [IDX_W-1:0] LAST_IDX_8  = 4'h2;
    localparam logic [RES_W-1:0] RES10_MAX   = 10'h3FF;
    localparam logic [RES_W-1:0] RES8_MAX    = 10'h0FF;

    localparam int CORE_CLK_MHZ   = 200;
    localparam int CNT_W          = 10;
    localparam int SYNC_BUS_CYC   = 3;
    localparam int ASYNC_START_NS = 5000;
    localparam int ASYNC_START_CYC = ASYNC_START_NS * CORE_CLK_MHZ / 1000;
    localparam int SAMPLE_SHORT_HALF = 7;
    localparam int SAMPLE_LONG_HALF  = 47;
    localparam logic [CNT_W-1:0] SYNC_LAST        = CNT_W'(SYNC_BUS_CYC - 1);
    localparam logic [CNT_W-1:0] ASYNC_START_LAST = CNT_W'(ASYNC_START_CYC - 1);
    localparam logic [CNT_W-1:0] SAMPLE_SHORT_TICKS = CNT_W'((SAMPLE_SHORT_HALF + 1) / 2);
    localparam logic [CNT_W-1:0] SAMPLE_LONG_TICKS  = CNT_W'((SAMPLE_LONG_HALF + 1) / 2);

    localparam logic [7:0] CONV_MAX_8S  = 8'h10;
    localparam logic [7:0] CONV_MAX_8L  = 8'h24;
    localparam logic [7:0] CONV_MAX_10S = 8'h13;
    localparam logic [7:0] CONV_MAX_10L = 8'h27;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SYNC    = 3'b001,
        ST_STARTUP = 3'b010,
        ST_SAMPLE  = 3'b011,
        ST_CONVERT = 3'b100,
        ST_ROUND   = 3'b101
    } conv_state_e;
endpackage

// ### rtl/converter_clock_divider.sv
`timescale 1ns/1ps
module converter_clock_divider #(
    parameter int DIV_W = 2
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             clear,
    input  wire logic             srcTick,
    input  wire logic [DIV_W-1:0] divSel,
    output logic                  tick
);
    localparam int CNT_W = (1 << DIV_W) - 1;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } div_s;

    div_s             st_r;
    div_s             st_nxt;
    logic [CNT_W-1:0] lastCnt;

    if (DIV_W < 1 || DIV_W > 4) begin : gCheck
        $error("divider width not supported");
    end

    always_comb begin
        lastCnt = CNT_W'((1 << divSel) - 1);
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (clear) begin
            st_nxt.cnt = '0;
        end else if (srcTick) begin
            if (st_r.cnt >= lastCnt) begin
                st_nxt.cnt = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule

// ### testbench/analog_input_model.sv
`timescale 1ns/1ps
module analog_input_model (
    input  wire logic [adc_seq_pkg::APPROX_W-1:0] analogLevel,
    input  wire logic [adc_seq_pkg::APPROX_W-1:0] dacCode,
    input  wire logic [adc_seq_pkg::CHAN_W-1:0]   channelSel,
    output logic                                  compGreater
);
    // the all-ones selection is the idle input, so it never reads high
    assign compGreater = (channelSel != adc_seq_pkg::CHAN_ALL_ONES) && (analogLevel >= dacCode);
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                             core_clk  = 1'b0;
    logic                             reset_n   = 1'b0;
    logic [adc_seq_pkg::ADDR_W-1:0]   regAddr   = 3'h0;
    logic [adc_seq_pkg::DATA_W-1:0]   regWrData = 8'h00;
    logic                             regWrite  = 1'b0;
    logic                             regRead   = 1'b0;
    logic                             stopMode  = 1'b0;
    logic [adc_seq_pkg::APPROX_W-1:0] level     = 11'h000;
    logic [adc_seq_pkg::APPROX_W-1:0] dacCode;
    logic [adc_seq_pkg::CHAN_W-1:0]   channelSel;
    logic [adc_seq_pkg::DATA_W-1:0]   regRdData;
    logic [7:0]                       expQ[$];
    logic [7:0]                       lastHi;
    logic [7:0]                       lastLo;
    logic                             converterOn;
    logic                             compGreater;
    logic                             completionIrq;
    logic                             rdSeen    = 1'b0;
    logic                             asyncPin  = 1'b0;
    logic                             sampleOn;
    logic                             asyncOscOn;
    int                               err_count = 0;
    int                               compares  = 0;

    always #2.5 core_clk = ~core_clk;

    // free-running stand-in for the asynchronous oscillator
    always @(posedge core_clk) asyncPin <= ~asyncPin;

    adc_conversion_sequencer uut (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .stopMode(stopMode), .altClkTick(1'b0), .asyncClkPin(asyncPin), .compGreater(compGreater),
        .converterOn(converterOn), .asyncOscOn(asyncOscOn), .sampleOn(sampleOn), .dacCode(dacCode),
        .channelSel(channelSel), .completionIrq(completionIrq));

    analog_input_model partner (.analogLevel(level), .dacCode(dacCode),
        .channelSel(channelSel), .compGreater(compGreater));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrite  <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge core_clk);
        regRead <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so it is taken exactly then
    always @(posedge core_clk) begin
        if (rdSeen) begin
            if (expQ.size() == 0) check("readQueue", 16'h0001, 16'h0000);
            else check("regRdData", {8'h00, regRdData}, {8'h00, expQ.pop_front()});
        end
        rdSeen <= regRead;
    end

    function automatic logic [9:0] rounded(input logic [10:0] lv, input bit wide);
        logic [11:0] s;
        s = wide ? {1'b0, lv} + 12'h001 : {3'h0, lv[10:2]} + 12'h001;
        s = s >> 1;
        if (wide && s > {2'h0, adc_seq_pkg::RES10_MAX}) s = 12'h3FF;
        if (!wide && s > {2'h0, adc_seq_pkg::RES8_MAX}) s = 12'h0FF;
        return s[9:0];
    endfunction

    task automatic convert(input logic [7:0] cfg, input int limit, input bit wide);
        int n;
        logic [10:0] lv;
        logic [9:0] r;
        lv = 11'($urandom % 2048);
        level <= lv;
        r = rounded(lv, wide);
        lastHi = wide ? {6'h00, r[9:8]} : 8'h00;
        lastLo = r[7:0];
        wr(adc_seq_pkg::OFS_CLOCK_CFG, cfg);
        wr(adc_seq_pkg::OFS_STATUS_CTRL, 8'h43);
        n = 1;
        while (completionIrq !== 1'b1) begin
            @(posedge core_clk);
            n++;
            if (n > limit + 400) begin
                check("completionTimeout", 16'h0001, 16'h0000);
                conclude();
            end
        end
        check("conversionCycles", {15'h0000, n <= limit}, 16'h0001);
        rd(adc_seq_pkg::OFS_STATUS_CTRL, 8'hC3);
        rd(adc_seq_pkg::OFS_RESULT_HIGH, lastHi);
        rd(adc_seq_pkg::OFS_RESULT_LOW, lastLo);
    endtask

    task automatic abortRun(input logic [2:0] a, input logic [7:0] d, input bit viaStop);
        wr(adc_seq_pkg::OFS_CLOCK_CFG, 8'h09);
        wr(adc_seq_pkg::OFS_STATUS_CTRL, 8'h43);
        repeat (6) @(posedge core_clk);
        check("converterOn", {15'h0000, converterOn}, 16'h0001);
        check("sampleOn", {15'h0000, sampleOn}, 16'h0001);
        if (viaStop) stopMode <= 1'b1;
        else wr(a, d);
        repeat (3) @(posedge core_clk);
        check("converterOn", {15'h0000, converterOn}, 16'h0000);
        check("sampleOn", {15'h0000, sampleOn}, 16'h0000);
        check("asyncOscOn", {15'h0000, asyncOscOn}, 16'h0000);
        stopMode <= 1'b0;
        repeat (40) @(posedge core_clk);
        check("completionIrq", {15'h0000, completionIrq}, 16'h0000);
        rd(adc_seq_pkg::OFS_RESULT_HIGH, lastHi);
        rd(adc_seq_pkg::OFS_RESULT_LOW, lastLo);
    endtask

    initial begin
        void'($urandom(32'h7E52));
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(adc_seq_pkg::OFS_RESULT_LOW, 8'h00);
        rd(3'h4, 8'h00);
        convert(8'h09, 27, 1'b1);
        convert(8'h01, 24, 1'b0);
        convert(8'h19, 47, 1'b1);
        convert(8'h11, 44, 1'b0);
        convert(8'h89, 1045, 1'b1);
        abortRun(adc_seq_pkg::OFS_STATUS_CTRL, 8'h5F, 1'b0);
        abortRun(adc_seq_pkg::OFS_CLOCK_CFG, 8'h09, 1'b0);
        abortRun(3'h0, 8'h00, 1'b1);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(adc_seq_pkg::OFS_RESULT_HIGH, 8'h00);
        rd(adc_seq_pkg::OFS_RESULT_LOW, 8'h00);
        repeat (3) @(posedge core_clk);
        conclude();
    end
endmodule
